// ===== verilog/dma_chan_req.sv
// Purpose: request generation and transfer sequencing of one dma channel
// Assumes: pins synchronous to clk; bus arbiter grants via bus_grant
// Notes:   apb slave with zero wait states; registers in the low byte of paddr
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/10ps
module dma_chan_req
	import dma_req_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        xfer_request_n,
	output logic             xfer_ack_n,
	output logic             bus_req,
	input  wire logic        bus_grant,
	input  wire logic        other_chan_owns,
	output logic             cyc_active,
	output logic             cyc_write,
	output logic             cyc_dest,
	input  wire logic        cyc_end,
	input  wire logic        cpu_cyc_end,
	output logic             cycle_complete_strobe_n
);
	chan_state_t s;
	chan_state_t next_s;
	logic        allow;
	logic        req_now;
	logic        owned;
	logic        ext;
	logic        single_eff;
	logic        steal_edge;
	logic        want;
	logic        ack_on;
	logic        op_end;
	logic        more;
	logic        wr_acc;
	logic        rd_set;
	logic        addr_ok;

	bw_limiter u_lim (
		.clk    (clk),
		.arst_n (arst_n),
		.bw     (s.bw),
		.owned  (owned),
		.allow  (allow)
	);

	assign req_now    = !xfer_request_n;
	assign ext        = (s.method == REQ_BURST) || (s.method == REQ_STEAL);
	// serial peripherals cannot take single address cycles
	assign single_eff = s.single && !s.serial;
	assign owned      = (s.st == ST_READ) || (s.st == ST_WRITE);
	// two consecutive asserted samples after a negated one make one request
	assign steal_edge = req_now && s.prev && s.armed;

	// requester side: source when hs_src, destination otherwise
	assign ack_on = ext && (((s.st == ST_READ) && s.hs_src) ||
		((s.st == ST_WRITE) && !s.hs_src));
	assign xfer_ack_n = !ack_on;

	assign op_end = cyc_end && ((s.st == ST_WRITE) || ((s.st == ST_READ) && single_eff));

	always_comb begin
		case (s.method)
			REQ_INTERNAL: want = allow && !s.single;
			REQ_BURST:    want = req_now;
			REQ_STEAL:    want = s.pend;
			default:      want = 1'b0;
		endcase
	end

	// decides at operand end whether the bus is kept for another transfer
	always_comb begin
		case (s.method)
			REQ_INTERNAL: more = allow;
			REQ_BURST:    more = s.again || req_now;
			REQ_STEAL:    more = s.pend || steal_edge;
			default:      more = 1'b0;
		endcase
	end

	assign bus_req    = s.start && !s.done && ((s.st == ST_ARB) || owned);
	assign cyc_active = owned;
	// single address: handshake on source means a read, else a write
	assign cyc_write  = (s.st == ST_WRITE);
	assign cyc_dest   = (s.st == ST_WRITE);

	assign addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_COUNT) || (paddr == OFS_STATUS);
	assign wr_acc  = psel && penable && pwrite && addr_ok;
	assign rd_set  = psel && !penable && !pwrite;
	assign pready  = 1'b1;
	assign pslverr = s.err && psel && penable;
	assign prdata  = s.rdata;
	assign cycle_complete_strobe_n = !s.strobe;

	always_comb begin
		next_s = s;
		// any finished bus cycle, cpu or dma, gives one strobe clock
		next_s.strobe = cyc_end || cpu_cyc_end;
		next_s.prev   = req_now;
		if (!req_now) begin
			next_s.armed = 1'b1;
		end
		if (s.method == REQ_BURST && ack_on && req_now) begin
			next_s.again = 1'b1;
		end
		// an edge while a request waits unacknowledged is dropped
		if (s.method == REQ_STEAL && steal_edge) begin
			next_s.armed = 1'b0;
			if (!s.pend || ack_on) begin
				next_s.pend = 1'b1;
			end
		end

		case (s.st)
			ST_IDLE: begin
				if (s.start && !s.done && want) begin
					next_s.st = ST_ARB;
				end
			end
			ST_ARB: begin
				if (!s.start) begin
					next_s.st = ST_IDLE;
				end else if (bus_grant && !other_chan_owns) begin
					next_s.st    = (single_eff && !s.hs_src) ? ST_WRITE : ST_READ;
					next_s.again = 1'b0;
					if (s.method == REQ_STEAL && !(steal_edge && s.pend)) begin
						next_s.pend = 1'b0;
					end
				end
			end
			ST_READ: begin
				if (cyc_end && !single_eff) begin
					next_s.st = ST_WRITE;
				end
			end
			ST_WRITE: begin
			end
			default: next_s.st = ST_IDLE;
		endcase

		if (op_end) begin
			next_s.cnt   = s.cnt - 1'b1;
			next_s.again = 1'b0;
			if (s.cnt <= 1) begin
				next_s.done  = 1'b1;
				next_s.start = 1'b0;
				next_s.st    = ST_IDLE;
			end else if (s.start && more) begin
				next_s.st = (single_eff && !s.hs_src) ? ST_WRITE : ST_READ;
				if (s.method == REQ_STEAL && !steal_edge) begin
					next_s.pend = 1'b0;
				end
			end else begin
				next_s.st = ST_IDLE;
			end
		end

		if (rd_set) begin
			next_s.err = !addr_ok;
			case (paddr)
				OFS_CTRL:   next_s.rdata = {24'h000000, s.serial, s.single, s.hs_src,
					s.bw, s.method, s.start};
				OFS_COUNT:  next_s.rdata = {{(32-CNT_W){1'b0}}, s.cnt};
				OFS_STATUS: next_s.rdata = {30'h00000000, s.done, (s.st != ST_IDLE)};
				default:    next_s.rdata = 32'h00000000;
			endcase
		end else if (psel && !penable) begin
			next_s.err = !addr_ok;
		end

		if (wr_acc) begin
			case (paddr)
				OFS_CTRL: begin
					next_s.start  = pwdata[B_START];
					next_s.method = req_method_t'(pwdata[B_METHOD +: 2]);
					next_s.bw     = pwdata[B_BW +: 2];
					next_s.hs_src = pwdata[B_HS_SRC];
					next_s.single = pwdata[B_SINGLE];
					next_s.serial = pwdata[B_SERIAL];
					if (pwdata[B_START]) begin
						next_s.pend = 1'b0;
					end
				end
				OFS_COUNT: next_s.cnt = pwdata[CNT_W-1:0];
				default: begin
					// done is write-one-to-clear; a completion this cycle wins
					if (pwdata[B_DONE] && !(op_end && s.cnt <= 1)) begin
						next_s.done = 1'b0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule

// ===== verilog/dma_req_pkg.sv
// Purpose: shared constants, enums and state records for the dma request channel
// Assumes: apb register access, one system clock
// Notes:   offsets are byte addresses on a 32-bit apb bus
package dma_req_pkg;
	localparam int          CNT_W       = 16;
	localparam int          WIN_W       = 10;
	localparam logic [7:0]  OFS_CTRL    = 8'h00;
	localparam logic [7:0]  OFS_COUNT   = 8'h04;
	localparam logic [7:0]  OFS_STATUS  = 8'h08;
	localparam int          B_START     = 0;
	localparam int          B_METHOD    = 1;
	localparam int          B_BW        = 3;
	localparam int          B_HS_SRC    = 5;
	localparam int          B_SINGLE    = 6;
	localparam int          B_SERIAL    = 7;
	localparam int          B_BUSY      = 0;
	localparam int          B_DONE      = 1;
	localparam logic [1:0]  BW_FULL     = 2'h0;
	localparam logic [1:0]  BW_75       = 2'h1;
	localparam logic [1:0]  BW_50       = 2'h2;
	localparam logic [1:0]  BW_25       = 2'h3;
	// window of 1024 clock periods and the owned-cycle quota for each share
	localparam logic [WIN_W:0] WIN_LEN  = 11'h400;
	localparam logic [WIN_W:0] Q_75     = 11'h300;
	localparam logic [WIN_W:0] Q_50     = 11'h200;
	localparam logic [WIN_W:0] Q_25     = 11'h100;

	typedef enum logic [1:0] {
		REQ_INTERNAL,
		REQ_BURST,
		REQ_STEAL,
		REQ_RSVD
	} req_method_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ARB,
		ST_READ,
		ST_WRITE
	} chan_st_t;

	typedef struct packed {
		logic [WIN_W-1:0] win;
		logic [WIN_W:0]   used;
	} lim_state_t;

	typedef struct packed {
		chan_st_t         st;
		logic             start;
		req_method_t      method;
		logic [1:0]       bw;
		logic             hs_src;
		logic             single;
		logic             serial;
		logic [CNT_W-1:0] cnt;
		logic             done;
		logic             pend;
		logic             again;
		logic             armed;
		logic             prev;
		logic             strobe;
		logic             err;
		logic [31:0]      rdata;
	} chan_state_t;
endpackage

// ===== verilog/bw_limiter.sv
// Purpose: bus bandwidth share limiter for internally generated requests
// Assumes: owned is high for each clock the channel holds the bus
// Notes:   quota resets at each window start, so a burst may straddle windows
`timescale 1ns/10ps
module bw_limiter
	import dma_req_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic [1:0] bw,
	input  wire logic       owned,
	output logic            allow
);
	lim_state_t       s;
	lim_state_t       next_s;
	logic [WIN_W:0]   quota;

	always_comb begin
		case (bw)
			BW_75:   quota = Q_75;
			BW_50:   quota = Q_50;
			BW_25:   quota = Q_25;
			default: quota = WIN_LEN;
		endcase
	end

	// full rate never stops asking until the block is done
	assign allow = (bw == BW_FULL) || (s.used < quota);

	always_comb begin
		next_s     = s;
		next_s.win = s.win + 1'b1;
		if (s.win == '1) begin
			next_s.used = '0;
		end else if (owned) begin
			next_s.used = s.used + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule

// ===== dv/dma_chan_req_assertions.sv
// Purpose: port-level checks of the dma request channel
// Assumes: one clock domain, async active-low reset
// Notes:   bound into every dma_chan_req instance
`timescale 1ns/10ps
module dma_chan_req_assertions
	import dma_req_pkg::*;
(
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic [7:0] paddr,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic       xfer_ack_n,
	input wire logic       bus_grant,
	input wire logic       other_chan_owns,
	input wire logic       cyc_active,
	input wire logic       cyc_write,
	input wire logic       cyc_dest,
	input wire logic       cyc_end,
	input wire logic       cpu_cyc_end,
	input wire logic       cycle_complete_strobe_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	strobe_after_a: assert property ((cyc_end || cpu_cyc_end) |=> !cycle_complete_strobe_n)
		else $error("no strobe after cycle end");
	strobe_cause_a: assert property (!cycle_complete_strobe_n |-> $past(cyc_end || cpu_cyc_end))
		else $error("strobe without cycle end");
	ack_in_cycle_a: assert property (!xfer_ack_n |-> cyc_active)
		else $error("ack outside bus cycle");
	ack_release_a: assert property ($rose(xfer_ack_n) |-> $past(cyc_end))
		else $error("ack dropped before cycle end");
	cycle_hold_a: assert property (cyc_active && !cyc_end |=> cyc_active && $stable(cyc_write))
		else $error("bus cycle changed early");
	grant_taken_a: assert property ($rose(cyc_active) |-> $past(bus_grant && !other_chan_owns))
		else $error("cycle without free grant");
	dest_addr_a: assert property (cyc_active |-> cyc_dest == cyc_write)
		else $error("destination flag wrong");
	read_first_a: assert property ($rose(cyc_write) && $past(cyc_active) |-> $past(cyc_end))
		else $error("write cut into read");
	apb_ready_a: assert property (psel && penable |-> pready)
		else $error("apb wait state");
	apb_unmapped_a: assert property (psel && penable && paddr != OFS_CTRL && paddr != OFS_COUNT
		&& paddr != OFS_STATUS |-> pslverr)
		else $error("unmapped access not refused");
	cover property (!xfer_ack_n);
	cover property (cyc_active && cyc_write);
	cover property (pslverr);
endmodule

bind dma_chan_req dma_chan_req_assertions chk_u (.clk(clk), .arst_n(arst_n), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.xfer_ack_n(xfer_ack_n), .bus_grant(bus_grant), .other_chan_owns(other_chan_owns),
	.cyc_active(cyc_active), .cyc_write(cyc_write), .cyc_dest(cyc_dest), .cyc_end(cyc_end),
	.cpu_cyc_end(cpu_cyc_end), .cycle_complete_strobe_n(cycle_complete_strobe_n));

// ===== dv/dma_peer.sv
// Purpose: peripheral and bus model facing the channel
// Assumes: mode 0 quiet, 1 burst level, 2 steal pulses
// Notes:   every bus cycle ends on its third clock
`timescale 1ns/10ps
module dma_peer (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic [1:0] mode,
	input  wire logic       bus_req,
	input  wire logic       cyc_active,
	output logic            xfer_request_n,
	output logic            bus_grant,
	output logic            cyc_end
);
	logic [3:0] tick;
	logic [1:0] len;
	// steal pulses last two clocks, one every sixteen
	// burst holds the level through ack
	assign xfer_request_n = !((mode == 2'h1) || (mode == 2'h2 && tick < 4'h2));
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tick <= 4'h0;
			len <= 2'h0;
			bus_grant <= 1'b0;
			cyc_end <= 1'b0;
		end else begin
			tick <= tick + 4'h1;
			bus_grant <= bus_req;
			cyc_end <= cyc_active && !cyc_end && len == 2'h1;
			len <= (cyc_active && !cyc_end) ? len + 2'h1 : 2'h0;
		end
	end
endmodule

// ===== dv/dma_chan_req_test.sv
// Purpose: register-driven scenarios for the dma request channel
// Assumes: apb slave, peer model on the request side
// Notes:   expected cycle and ack counts follow from the transfer mode
`timescale 1ns/10ps
module dma_chan_req_test;
	import dma_req_pkg::*;
	logic        clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, cpu_cyc_end = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd;
	logic [1:0]  mode = 2'h0;
	logic        pready, pslverr, req_n, ack_n, bus_req, grant, act, wr, cend, strobe_n, dst;
	logic [31:0] prdata;
	int          error_cnt = 0, comparisons = 0, cycs = 0, acks = 0, wrs = 0;
	always #2 clk = !clk;
	dma_chan_req dut_u (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .xfer_request_n(req_n), .xfer_ack_n(ack_n), .bus_req(bus_req),
		.bus_grant(grant), .other_chan_owns(1'b0), .cyc_active(act), .cyc_write(wr),
		.cyc_dest(dst), .cyc_end(cend), .cpu_cyc_end(cpu_cyc_end),
		.cycle_complete_strobe_n(strobe_n));
	dma_peer peer_u (.clk(clk), .arst_n(arst_n), .mode(mode), .bus_req(bus_req),
		.cyc_active(act), .xfer_request_n(req_n), .bus_grant(grant), .cyc_end(cend));
	always @(posedge clk) begin
		cycs = cycs + (act && cend);
		acks = acks + (cend && !ack_n);
		// counts ended cycles that are both destination-addressed and writes
		wrs = wrs + (cend && dst && wr);
	end
	task final_report;
		if (error_cnt == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// one apb transfer; data and error are taken at the ready edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic e);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task run(input logic [7:0] ctl, input logic [31:0] n, input logic [1:0] md,
		input int ec, input int ea, input int ew);
		logic e;
		apb(1, OFS_COUNT, n, e);
		cycs = 0;
		acks = 0;
		wrs = 0;
		mode <= md;
		apb(1, OFS_CTRL, {24'h0, ctl}, e);
		repeat (300) begin
			apb(0, OFS_STATUS, 0, e);
			if (rd[B_DONE] === 1'b1)
				break;
		end
		chk("status", 32'h2, rd);
		chk("cycles", ec, cycs);
		chk("acks", ea, acks);
		chk("dest cycles", ew, wrs);
		apb(1, OFS_STATUS, 32'h2, e);
		mode <= 0;
	endtask
	initial begin
		logic e;
		repeat (20) @(posedge clk);
		arst_n <= 1;
		apb(0, OFS_CTRL, 0, e);
		chk("ctrl", 0, rd);
		apb(0, 8'h0c, 0, e);
		chk("unmapped", 1, e);
		apb(1, OFS_COUNT, 32'hffffffff, e);
		apb(0, OFS_COUNT, 0, e);
		chk("count", 32'hffff, rd);
		cpu_cyc_end <= 1;
		@(posedge clk);
		cpu_cyc_end <= 0;
		#1 chk("strobe", 0, strobe_n);
		run(8'h01, 2, 0, 4, 0, 2);
		run(8'h19, 2, 0, 4, 0, 2);
		run(8'h65, 2, 2, 2, 2, 0);
		run(8'h03, 3, 1, 6, 3, 3);
		run(8'h43, 2, 1, 2, 2, 2);
		run(8'hc5, 1, 2, 2, 1, 1);
		// no transfer may start: internal single, external without request
		run_idle(8'h41);
		run_idle(8'h03);
		final_report;
	end
	task run_idle(input logic [7:0] ctl);
		logic e;
		apb(1, OFS_COUNT, 1, e);
		cycs = 0;
		apb(1, OFS_CTRL, {24'h0, ctl}, e);
		repeat (100) @(posedge clk);
		chk("idle cycles", 0, cycs);
		apb(1, OFS_CTRL, 0, e);
	endtask
	initial begin
		#200000;
		error_cnt++;
		final_report;
	end
endmodule
